// ---- jacr_defs.vh ----
// constants for the jitter attenuator control register bank
`ifndef JACR_DEFS_VH
`define JACR_DEFS_VH
`define JACR_ADDR_W 8
`define JACR_ADDR_CH0 8'h07
`define JACR_ADDR_CH1 8'h0f
`define JACR_ADDR_CH2 8'h17
`define JACR_RESET_VAL 8'h03
`define JACR_RESET_BITS 5'h03
`define JACR_WR_MASK 8'h1f
`define JACR_BIT_DEPTH_LO 0
`define JACR_BIT_PATH 1
`define JACR_BIT_DEPTH_HI 2
`define JACR_BIT_FLUSH 3
`define JACR_BIT_FAST_DIS 4
`define JACR_NUM_CH 3
`endif

// ---- jacr_chan_reg.v ----
// one channel of the jitter attenuator control register
`timescale 1ns/1ps
`default_nettype none
`include "jacr_defs.vh"
module jacr_chan_reg (
    input wire clk_sys_i,
    input wire rst_i,
    input wire wr_en_i,
    input wire [7:0] wr_data_i,
    input wire host_mode_i,
    output wire [7:0] rd_data_o,
    output wire fifo_depth_sel_lo_o,
    output wire fifo_depth_sel_hi_o,
    output wire jitter_path_select_o,
    output wire jitter_fifo_flush_o,
    output wire fast_recovery_en_o
);
    reg [4:0] ctrl_q;
    wire [4:0] ctrl_d;

    assign ctrl_d = wr_en_i ? wr_data_i[4:0] : ctrl_q;

    always @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            ctrl_q <= `JACR_RESET_BITS;
        end else begin
            ctrl_q <= ctrl_d;
        end
    end

    // upper bits read as zero
    assign rd_data_o = {3'h0, ctrl_q};
    assign fifo_depth_sel_lo_o = ctrl_q[`JACR_BIT_DEPTH_LO];
    assign fifo_depth_sel_hi_o = ctrl_q[`JACR_BIT_DEPTH_HI];
    assign jitter_path_select_o = ctrl_q[`JACR_BIT_PATH];
    assign jitter_fifo_flush_o = ctrl_q[`JACR_BIT_FLUSH];
    // the stored bit stays readable; pin mode simply overrides its effect
    assign fast_recovery_en_o = ~(ctrl_q[`JACR_BIT_FAST_DIS] & host_mode_i);
endmodule // jacr_chan_reg
`default_nettype wire

// ---- jacr_bank.v ----
// jitter attenuator control register bank, three channels
`timescale 1ns/1ps
`default_nettype none
`include "jacr_defs.vh"
module jacr_bank (
    input wire clk_sys_i,
    input wire rst_i,
    input wire host_mode_i,
    input wire [7:0] addr_i,
    input wire wr_i,
    input wire rd_i,
    input wire [7:0] wr_data_i,
    output wire [7:0] rd_data_o,
    output wire [2:0] fifo_depth_sel_lo_o,
    output wire [2:0] fifo_depth_sel_hi_o,
    output wire [2:0] jitter_path_select_o,
    output wire [2:0] jitter_fifo_flush_o,
    output wire [2:0] fast_recovery_en_o
);
    // ****************************************
    // one-hot channel codes
    // ****************************************
    // bit n stands for channel n; all zero means no channel
    localparam [2:0] HIT_NONE = 3'b000;
    localparam [2:0] HIT_CH0 = 3'b001;
    localparam [2:0] HIT_CH1 = 3'b010;
    localparam [2:0] HIT_CH2 = 3'b100;

    // ****************************************
    // address decode
    // ****************************************
    // exact match only, so aliases of the three addresses are refused
    function [2:0] ch_hit;
        input [7:0] a;
        begin
            case (a)
                `JACR_ADDR_CH0: begin
                    ch_hit = HIT_CH0;
                end
                `JACR_ADDR_CH1: begin
                    ch_hit = HIT_CH1;
                end
                `JACR_ADDR_CH2: begin
                    ch_hit = HIT_CH2;
                end
                default: begin
                    ch_hit = HIT_NONE;
                end
            endcase
        end
    endfunction

    // ****************************************
    // write data shaping
    // ****************************************
    // top three bits are never stored
    function [7:0] wr_field;
        input [7:0] d;
        begin
            wr_field = d & `JACR_WR_MASK;
        end
    endfunction

    // ****************************************
    // decode results and per-channel nets
    // ****************************************
    wire [2:0] wr_hit;
    wire [2:0] rd_hit;
    wire [7:0] wr_word;
    wire wr_ch0;
    wire wr_ch1;
    wire wr_ch2;
    wire [7:0] rd_ch0;
    wire [7:0] rd_ch1;
    wire [7:0] rd_ch2;

    wire ch0_depth_lo;
    wire ch0_depth_hi;
    wire ch0_path;
    wire ch0_flush;
    wire ch0_fast_en;

    wire ch1_depth_lo;
    wire ch1_depth_hi;
    wire ch1_path;
    wire ch1_flush;
    wire ch1_fast_en;

    wire ch2_depth_lo;
    wire ch2_depth_hi;
    wire ch2_path;
    wire ch2_flush;
    wire ch2_fast_en;

    reg [7:0] rd_data_d;
    reg [7:0] rd_data_q;

    // ****************************************
    // strobe qualification
    // ****************************************
    // one decoder serves both strobes, so a read and a write never disagree
    assign wr_hit = wr_i ? ch_hit(addr_i) : HIT_NONE;
    assign rd_hit = rd_i ? ch_hit(addr_i) : HIT_NONE;
    assign wr_word = wr_field(wr_data_i);
    // a write strobe reaches one channel only
    assign wr_ch0 = wr_hit[0];
    assign wr_ch1 = wr_hit[1];
    assign wr_ch2 = wr_hit[2];

    // ****************************************
    // channel 0
    // ****************************************
    jacr_chan_reg u_ch0 (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .wr_en_i(wr_ch0),
        .wr_data_i(wr_word),
        .host_mode_i(host_mode_i),
        .rd_data_o(rd_ch0),
        .fifo_depth_sel_lo_o(ch0_depth_lo),
        .fifo_depth_sel_hi_o(ch0_depth_hi),
        .jitter_path_select_o(ch0_path),
        .jitter_fifo_flush_o(ch0_flush),
        .fast_recovery_en_o(ch0_fast_en)
    );

    // ****************************************
    // channel 1
    // ****************************************
    jacr_chan_reg u_ch1 (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .wr_en_i(wr_ch1),
        .wr_data_i(wr_word),
        .host_mode_i(host_mode_i),
        .rd_data_o(rd_ch1),
        .fifo_depth_sel_lo_o(ch1_depth_lo),
        .fifo_depth_sel_hi_o(ch1_depth_hi),
        .jitter_path_select_o(ch1_path),
        .jitter_fifo_flush_o(ch1_flush),
        .fast_recovery_en_o(ch1_fast_en)
    );

    // ****************************************
    // channel 2
    // ****************************************
    jacr_chan_reg u_ch2 (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .wr_en_i(wr_ch2),
        .wr_data_i(wr_word),
        .host_mode_i(host_mode_i),
        .rd_data_o(rd_ch2),
        .fifo_depth_sel_lo_o(ch2_depth_lo),
        .fifo_depth_sel_hi_o(ch2_depth_hi),
        .jitter_path_select_o(ch2_path),
        .jitter_fifo_flush_o(ch2_flush),
        .fast_recovery_en_o(ch2_fast_en)
    );

    // ****************************************
    // output fan-out
    // ****************************************
    // bit n of every control bus belongs to channel n alone
    assign fifo_depth_sel_lo_o[0] = ch0_depth_lo;
    assign fifo_depth_sel_hi_o[0] = ch0_depth_hi;
    assign jitter_path_select_o[0] = ch0_path;
    assign jitter_fifo_flush_o[0] = ch0_flush;
    assign fast_recovery_en_o[0] = ch0_fast_en;

    assign fifo_depth_sel_lo_o[1] = ch1_depth_lo;
    assign fifo_depth_sel_hi_o[1] = ch1_depth_hi;
    assign jitter_path_select_o[1] = ch1_path;
    assign jitter_fifo_flush_o[1] = ch1_flush;
    assign fast_recovery_en_o[1] = ch1_fast_en;

    assign fifo_depth_sel_lo_o[2] = ch2_depth_lo;
    assign fifo_depth_sel_hi_o[2] = ch2_depth_hi;
    assign jitter_path_select_o[2] = ch2_path;
    assign jitter_fifo_flush_o[2] = ch2_flush;
    assign fast_recovery_en_o[2] = ch2_fast_en;

    // ****************************************
    // read select
    // ****************************************
    // unmapped reads give zero rather than the last word
    always @* begin
        rd_data_d = 8'h00;
        case (rd_hit)
            HIT_CH0: begin
                rd_data_d = rd_ch0;
            end
            HIT_CH1: begin
                rd_data_d = rd_ch1;
            end
            HIT_CH2: begin
                rd_data_d = rd_ch2;
            end
            default: begin
                rd_data_d = 8'h00;
            end
        endcase
    end

    // ****************************************
    // read data register
    // ****************************************
    // holds until the next read strobe; a write in the same cycle is not seen
    always @(posedge clk_sys_i or posedge rst_i) begin
        if (rst_i) begin
            rd_data_q <= 8'h00;
        end else if (rd_i) begin
            rd_data_q <= rd_data_d;
        end
    end

    assign rd_data_o = rd_data_q;
endmodule // jacr_bank
`default_nettype wire

// ---- jacr_chk_assertions.sv ----
// checker for the jitter attenuator control bank
`timescale 1ns/1ps
`default_nettype none
module jacr_chk (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic host_mode_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wr_data_i,
    input wire logic [7:0] rd_data_o,
    input wire logic [2:0] fifo_depth_sel_lo_o,
    input wire logic [2:0] fast_recovery_en_o
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);
    hi_zero_a: assert property (rd_data_o[7:5] == 3'h0) else $error("top set");
    pin_on_a: assert property (!host_mode_i |-> &fast_recovery_en_o) else $error("pin");
    dis_host_a: assert property (wr_i && addr_i == 8'h0f && wr_data_i[4]
        ##1 host_mode_i |-> !fast_recovery_en_o[1]) else $error("dis");
    keep_on_a: assert property (wr_i && addr_i == 8'h0f && !wr_data_i[4]
        |=> fast_recovery_en_o[1]) else $error("keep");
    unmap_a: assert property (rd_i && !(addr_i inside {8'h07, 8'h0f, 8'h17})
        |=> rd_data_o == 8'h00) else $error("unmap");
    own_ch_a: assert property (wr_i && addr_i == 8'h07
        |=> $stable(fifo_depth_sel_lo_o[2:1])) else $error("other ch");
    cover property (wr_i && host_mode_i && wr_data_i[4]);
    cover property (!host_mode_i && rd_i);
    cover property (rd_i && addr_i == 8'h17);
endmodule // jacr_chk
bind jacr_bank jacr_chk u_chk (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .host_mode_i(host_mode_i),
    .wr_i(wr_i), .rd_i(rd_i), .addr_i(addr_i), .wr_data_i(wr_data_i), .rd_data_o(rd_data_o),
    .fifo_depth_sel_lo_o(fifo_depth_sel_lo_o), .fast_recovery_en_o(fast_recovery_en_o));
`default_nettype wire

// ---- testbench.sv ----
// self-checking bench for the control bank
`timescale 1ns/1ps
`default_nettype none
`define CHK(a,b) begin cmp_count++; if ((a)!==(b)) begin failures++; $display("ERROR %0t %h %h", $time, a, b); end end
module testbench;
    logic clk_sys_i=0, rst_i=1, host_mode_i=0, wr_i=0, rd_i=0, rv=0;
    logic [7:0] addr_i=0, wr_data_i=0, rd_data_o, d;
    logic [2:0] lo, hi, pa, fl, fe;
    int failures=0, cmp_count=0, cyc=0;
    logic [7:0] q[$];
    jacr_bank uut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .host_mode_i(host_mode_i), .addr_i(addr_i),
        .wr_i(wr_i), .rd_i(rd_i), .wr_data_i(wr_data_i), .rd_data_o(rd_data_o), .fifo_depth_sel_lo_o(lo),
        .fifo_depth_sel_hi_o(hi), .jitter_path_select_o(pa), .jitter_fifo_flush_o(fl),
        .fast_recovery_en_o(fe));
    always #50 clk_sys_i = ~clk_sys_i;
    always @(posedge clk_sys_i) begin
        rv <= rd_i;
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            failures++;
            wrap_up;
        end
    end
    // read data lands one edge after the strobe
    always @(negedge clk_sys_i) if (rv) begin
        `CHK(rd_data_o, q[0])
        void'(q.pop_front());
    end
    task acc(input logic w, input logic [7:0] a, x, e);
        @(posedge clk_sys_i);
        #1 {wr_i, rd_i, addr_i, wr_data_i} = {w, !w, a, x};
        if (!w) q.push_back(e);
        @(posedge clk_sys_i);
        #1 {wr_i, rd_i} = 2'h0;
    endtask
    task wrap_up;
        `CHK(q.size(), 0)
        $display("failures %0d cmp_count %0d", failures, cmp_count);
        if (failures == 0 && cmp_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        void'($urandom(32'he099008f));
        repeat (6) @(posedge clk_sys_i);
        #1 rst_i = 0;
        for (int i = 0; i < 3; i++) acc(0, 8'h07 + 8'(8 * i), 0, 8'h03);
        `CHK(fe, 3'h7)
        host_mode_i = 1;
        acc(1, 8'h0f, 8'hff, 0);
        `CHK(fe, 3'h5)
        `CHK(hi, 3'h2)
        acc(0, 8'h0f, 0, 8'h1f);
        host_mode_i = 0;
        #1 `CHK(fe, 3'h7)
        for (int i = 0; i < 3; i++) acc(1, 8'h07 + 8'(8 * i), 8'h06, 0);
        `CHK({lo, hi, pa}, 9'h03f)
        // flush bit forced so the unmapped read below has a nonzero word to clear
        d = 8'($urandom) | 8'h08;
        acc(1, 8'h17, d, 0);
        `CHK(fl, 3'h4)
        `CHK(fe, 3'h7)
        acc(0, 8'h17, 0, d & 8'h1f);
        d = 8'($urandom) | 8'h20;
        acc(0, d, 0, 8'h00);
        // let the unmapped read be checked before reset clears the read word
        repeat (2) @(posedge clk_sys_i);
        #1 rst_i = 1;
        #200 rst_i = 0;
        `CHK({lo, hi, pa, fl}, 12'he38)
        acc(0, 8'h07, 0, 8'h03);
        repeat (2) @(posedge clk_sys_i);
        wrap_up;
    end
endmodule // testbench
`default_nettype wire
